// File: iprl_pkg.sv
package iprl_pkg;
   // register offsets (byte addresses on the plain register port)
   localparam logic [7:0] OFS_CFG = 8'h03;
   localparam logic [7:0] OFS_LIM0 = 8'h10;
   localparam logic [7:0] OFS_LIM7 = 8'h17;
   localparam logic [7:0] OFS_STAT = 8'h20;
   // config register field positions
   localparam int CFG_PORT_BIT = 6;
   localparam int CFG_PPS_BIT = 5;
   localparam int CFG_FC_BIT = 4;
   localparam int CFG_CLS_LSB = 2;
   localparam int CFG_IFG_BIT = 1;
   localparam int CFG_PRE_BIT = 0;
   // status register field positions
   localparam int STAT_FC_BIT = 0;
   localparam int STAT_DROP_BIT = 1;
   // reset values
   localparam logic [6:0] CFG_RST = 7'h00;
   localparam logic [6:0] LIM_RST = 7'h00;
   localparam int NUM_PRIO = 8;
   // frame classes counted against the limit
   localparam logic [1:0] CLS_ALL = 2'h0;
   localparam logic [1:0] CLS_BMF = 2'h1;
   localparam logic [1:0] CLS_BM = 2'h2;
   localparam logic [1:0] CLS_B = 2'h3;
   // per-frame byte additions
   localparam logic [31:0] IFG_BYTES = 32'hc;
   localparam logic [31:0] PRE_BYTES = 32'h8;
   // packets are charged in hundredths so that packet rates stay integral
   localparam logic [31:0] PKT_COST = 32'h64;
   // refill period and clock
   localparam int REFILL_PERIOD_US = 10000;
   localparam int CLK_MHZ = 250;
   localparam int REFILL_CYCLES = REFILL_PERIOD_US * CLK_MHZ;
   // code ranges
   localparam logic [6:0] CODE_STEP_MAX = 7'h0a;
   localparam logic [6:0] CODE_LIN_MAX = 7'h64;
   localparam logic [6:0] CODE_SUB_MIN = 7'h65;
   localparam logic [6:0] CODE_SUB_MAX = 7'h73;
   localparam logic [6:0] CODE_SUB_BIG = 7'h67;
   // credits per refill period (bits, or packets times 100)
   localparam logic [31:0] BPS_LINE_10 = 32'd100000;
   localparam logic [31:0] BPS_LINE_100 = 32'd1000000;
   localparam logic [31:0] BPS_LINE_1000 = 32'd10000000;
   localparam logic [31:0] BPS_STEP_1M = 32'd10000;
   localparam logic [31:0] BPS_STEP_10M = 32'd100000;
   localparam logic [31:0] BPS_SUB_64K = 32'd640;
   localparam logic [31:0] BPS_SUB_640K = 32'd6400;
   localparam logic [31:0] PPS_LINE_10 = 32'd19200;
   localparam logic [31:0] PPS_LINE_100 = 32'd192000;
   localparam logic [31:0] PPS_LINE_1000 = 32'd1920000;
   localparam logic [31:0] PPS_STEP_LO = 32'd1920;
   localparam logic [31:0] PPS_STEP_HI = 32'd19200;
   localparam logic [31:0] PPS_SUB_FIRST = 32'd64;
   localparam logic [31:0] PPS_SUB_STEP = 32'd128;
   localparam logic [31:0] SUB_GIG_MUL = 32'd10;

   typedef enum logic [1:0] {
      SPD_10 = 2'b00,
      SPD_100 = 2'b01,
      SPD_1000 = 2'b10
   } iprl_speed_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_FILL = 1'b1
   } iprl_state_e;
endpackage

// File: iprl_rate_dec.sv
`timescale 1ns/1ps
`default_nettype none
module iprl_rate_dec
   import iprl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [6:0] code,
   input wire logic [1:0] speed,
   input wire logic pps,
   output logic [31:0] rate,
   output logic unlimited
);

   function automatic logic [31:0] rate_of(input logic [6:0] c, input logic [1:0] s,
                                           input logic p);
      logic [31:0] n;
      logic [31:0] m;
      logic [31:0] v;
      n = {25'h0, c};
      m = n - {25'h0, CODE_LIN_MAX};
      v = 32'h0;
      if (c == 7'h00) begin
         case (s)
            SPD_10: v = p ? PPS_LINE_10 : BPS_LINE_10;
            SPD_100: v = p ? PPS_LINE_100 : BPS_LINE_100;
            default: v = p ? PPS_LINE_1000 : BPS_LINE_1000;
         endcase
      end else if (c <= CODE_LIN_MAX) begin
         if (p) begin
            // codes above the step range are undefined at 10M: hold at the last one
            if (s == SPD_1000) v = PPS_STEP_HI * n;
            else if (s == SPD_10 && c > CODE_STEP_MAX) v = PPS_STEP_HI;
            else v = PPS_STEP_LO * n;
         end else if (c <= CODE_STEP_MAX || s == SPD_100) begin
            v = BPS_STEP_1M * n;
         end else if (s == SPD_10) begin
            v = BPS_LINE_10;
         end else begin
            v = BPS_STEP_10M * n;
         end
      end else begin
         if (p) begin
            v = (c == CODE_SUB_MIN) ? PPS_SUB_FIRST : PPS_SUB_STEP * (m - 32'h1);
            if (s == SPD_1000) v = v * SUB_GIG_MUL;
         end else if (s == SPD_1000 || (s == SPD_100 && c <= CODE_SUB_BIG)) begin
            v = BPS_SUB_640K * m;
         end else begin
            v = BPS_SUB_64K * m;
         end
      end
      return v;
   endfunction

   // registered so the long multiply chain never meets the bucket adders
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rate <= 32'h0;
         unlimited <= 1'b0;
      end else begin
         rate <= rate_of(code, speed, pps);
         unlimited <= (code > CODE_SUB_MAX);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   step_bits_a: assert property (!pps && code != 7'h00 && code <= CODE_STEP_MAX
      |=> rate == BPS_STEP_1M * {25'h0, $past(code)})
      else $error("bit-rate step code gave wrong credit");
   line_pps_a: assert property (pps && code == 7'h00 && speed == SPD_1000
      |=> rate == PPS_LINE_1000)
      else $error("packet line rate at 1000M wrong");
   sub_gig_a: assert property (!pps && code == CODE_SUB_MIN && speed == SPD_1000
      |=> rate == BPS_SUB_640K)
      else $error("first sub-megabit code at 1000M wrong");
   speed_map_a: assert property (!pps && code == 7'h00 && speed == SPD_100
      |=> rate == BPS_LINE_100)
      else $error("line rate does not follow link speed");
endmodule
`default_nettype wire

// File: iprl_limiter.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - config bit 6 set meters the whole port with one limit, clear meters each priority.
// - config bit 5 set meters packets, clear meters bits.
// - bit 4 with port flow control enabled raises flow control on overrun instead of dropping.
// - bits 3:2 pick counted frames: all, bcast+mcast+flood, bcast+mcast, bcast only.
// - bit 1 adds twelve gap bytes per frame to the bit count.
// - bit 0 adds eight preamble bytes per frame to the bit count.
// - the preamble bit has no effect in packet mode.
// - priority 0 holds a 7-bit limit code, top bit reads zero, resets to zero.
// - limit codes take effect only when the priority 7 register is written.
// - in bit mode the code maps to line rate, 1 Mbps steps or 10 Mbps steps by speed.
// - in packet mode the code maps to 1.92k or 19.2k packets per second steps.
// - codes 101 to 115 select low bit rates in 64 kbps steps (640 kbps steps at 1000M and for codes 101 to 103 at 100M) and low packet rates.
// - priorities 1 to 7 have the same 7-bit limit registers.
module iprl_limiter
   import iprl_pkg::*;
#(
   parameter int TICK_CYCLES = REFILL_CYCLES,
   parameter int LEN_W = 14
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] link_speed,
   input wire logic fc_enable,
   input wire logic frm_valid,
   input wire logic [LEN_W-1:0] frm_len,
   input wire logic [2:0] frm_prio,
   input wire logic frm_bcast,
   input wire logic frm_mcast,
   input wire logic frm_flood,
   output logic frm_done,
   output logic frm_drop,
   output logic flow_ctrl
);

   function automatic logic class_hit(input logic [1:0] m, input logic b, input logic mc,
                                      input logic f);
      case (m)
         CLS_ALL: class_hit = 1'b1;
         CLS_BMF: class_hit = b | mc | f;
         CLS_BM: class_hit = b | mc;
         CLS_B: class_hit = b;
         default: class_hit = 1'b1;
      endcase
   endfunction

   logic [6:0] cfg;
   logic [6:0] lim_shadow [NUM_PRIO];
   logic [6:0] lim_act [NUM_PRIO];
   logic [31:0] credit [NUM_PRIO];
   logic unl [NUM_PRIO];
   logic drop_seen;
   logic [31:0] tick_cnt;
   logic tick;
   iprl_state_e state;
   logic [2:0] fill_idx;
   logic [2:0] fill_bkt;
   logic fill_vld;
   logic [31:0] dec_rate;
   logic dec_unl;
   logic port_mode;
   logic pps_mode;
   logic fc_on;
   logic counted;
   logic [2:0] bkt;
   logic [31:0] cost;
   logic [31:0] bytes;
   logic conform;
   logic over;
   logic stat_rd;

   assign port_mode = cfg[CFG_PORT_BIT];
   assign pps_mode = cfg[CFG_PPS_BIT];
   assign fc_on = cfg[CFG_FC_BIT] & fc_enable;
   assign stat_rd = reg_rd && reg_addr == OFS_STAT;

   // register writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg <= CFG_RST;
      end else if (reg_wr && reg_addr == OFS_CFG) begin
         cfg <= reg_wdata[6:0];
      end
   end

   // written codes sit in a shadow until the priority 7 write commits them all
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_PRIO; i++) begin
            lim_shadow[i] <= LIM_RST;
            lim_act[i] <= LIM_RST;
         end
      end else if (reg_wr && reg_addr >= OFS_LIM0 && reg_addr <= OFS_LIM7) begin
         lim_shadow[reg_addr[2:0]] <= reg_wdata[6:0];
         if (reg_addr == OFS_LIM7) begin
            for (int i = 0; i < NUM_PRIO - 1; i++) begin
               lim_act[i] <= lim_shadow[i];
            end
            lim_act[NUM_PRIO-1] <= reg_wdata[6:0];
         end
      end
   end

   // read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == OFS_CFG) begin
            reg_rdata <= {1'b0, cfg};
         end else if (reg_addr >= OFS_LIM0 && reg_addr <= OFS_LIM7) begin
            reg_rdata <= {1'b0, lim_shadow[reg_addr[2:0]]};
         end else if (stat_rd) begin
            reg_rdata <= {6'h00, drop_seen, flow_ctrl};
         end else begin
            reg_rdata <= 8'h00;
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // refill period divider
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_cnt <= 32'h0;
         tick <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
         tick_cnt <= 32'h0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick <= 1'b0;
      end
   end

   // one decoder is shared: the refill walks the eight buckets in turn
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         fill_idx <= 3'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               fill_idx <= 3'h0;
               if (tick) state <= ST_FILL;
            end
            ST_FILL: begin
               fill_idx <= fill_idx + 3'h1;
               if (fill_idx == 3'h7) state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fill_vld <= 1'b0;
         fill_bkt <= 3'h0;
      end else begin
         fill_vld <= (state == ST_FILL);
         fill_bkt <= fill_idx;
      end
   end

   iprl_rate_dec u_dec (
      .core_clk(core_clk),
      .rst(rst),
      .code(lim_act[fill_idx]),
      .speed(link_speed),
      .pps(pps_mode),
      .rate(dec_rate),
      .unlimited(dec_unl)
   );

   // frame charge
   always_comb begin
      bytes = {{(32-LEN_W){1'b0}}, frm_len};
      if (cfg[CFG_IFG_BIT]) bytes = bytes + IFG_BYTES;
      if (cfg[CFG_PRE_BIT]) bytes = bytes + PRE_BYTES;
      // preamble bytes only matter to the bit count, so packet mode ignores them
      cost = pps_mode ? PKT_COST : {bytes[28:0], 3'b000};
   end

   assign bkt = port_mode ? 3'h0 : frm_prio;
   assign counted = class_hit(cfg[CFG_CLS_LSB +: 2], frm_bcast, frm_mcast, frm_flood);
   assign conform = unl[bkt] || credit[bkt] >= cost;
   assign over = frm_valid && counted && !conform;

   // a refill resets the window; a charge landing on that bucket the same cycle is lost
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_PRIO; i++) begin
            credit[i] <= 32'h0;
            unl[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < NUM_PRIO; i++) begin
            if (fill_vld && fill_bkt == 3'(i)) begin
               credit[i] <= dec_rate;
               unl[i] <= dec_unl;
            end else if (frm_valid && counted && bkt == 3'(i) && !unl[i]) begin
               credit[i] <= (credit[i] >= cost) ? credit[i] - cost : 32'h0;
            end
         end
      end
   end

   // verdict one cycle after the descriptor
   always_ff @(posedge core_clk) begin
      if (rst) begin
         frm_done <= 1'b0;
         frm_drop <= 1'b0;
      end else begin
         frm_done <= frm_valid;
         frm_drop <= over && !fc_on;
      end
   end

   // flow control holds until the next refill starts or the feature is turned off
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flow_ctrl <= 1'b0;
      end else if (!fc_on) begin
         flow_ctrl <= 1'b0;
      end else if (over) begin
         flow_ctrl <= 1'b1;
      end else if (tick) begin
         flow_ctrl <= 1'b0;
      end
   end

   // sticky drop flag, cleared by a status read; a new drop wins over the clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         drop_seen <= 1'b0;
      end else if (over && !fc_on) begin
         drop_seen <= 1'b1;
      end else if (stat_rd) begin
         drop_seen <= 1'b0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   port_bucket_a: assert property (port_mode |-> bkt == 3'h0)
      else $error("port mode did not use the single bucket");
   pps_cost_a: assert property (pps_mode |-> cost == PKT_COST)
      else $error("packet mode charge wrong");
   fc_no_drop_a: assert property (frm_valid && fc_on |=> frm_done && !frm_drop)
      else $error("frame dropped while flow control mode on");
   fc_gate_a: assert property (!fc_on |=> !flow_ctrl)
      else $error("flow control raised without enable");
   uncounted_pass_a: assert property (frm_valid && !counted |=> frm_done && !frm_drop)
      else $error("uncounted class was dropped");
   ifg_cost_a: assert property (!pps_mode && cfg[CFG_IFG_BIT] && !cfg[CFG_PRE_BIT]
      |-> cost == ({{(32-LEN_W){1'b0}}, frm_len} + IFG_BYTES) * 32'h8)
      else $error("gap bytes not charged");
   pre_cost_a: assert property (!pps_mode && !cfg[CFG_IFG_BIT] && cfg[CFG_PRE_BIT]
      |-> cost == ({{(32-LEN_W){1'b0}}, frm_len} + PRE_BYTES) * 32'h8)
      else $error("preamble bytes not charged");
   lim_top_a: assert property (reg_rd && reg_addr >= OFS_LIM0 && reg_addr <= OFS_LIM7
      |=> reg_rdata[7] == 1'b0)
      else $error("limit top bit not zero");
   commit_hold_a: assert property (reg_wr && reg_addr == OFS_LIM0
      |=> lim_act[0] == $past(lim_act[0]))
      else $error("limit applied before priority 7 write");
   commit_apply_a: assert property (reg_wr && reg_addr == OFS_LIM7
      |=> lim_act[0] == lim_shadow[0] && lim_act[7] == $past(reg_wdata[6:0]))
      else $error("priority 7 write did not commit codes");
   over_drop_a: assert property (over && !fc_on |=> frm_done && frm_drop
      ##1 (!frm_drop || $past(frm_valid)))
      else $error("overrun frame not dropped");
   done_pulse_a: assert property (frm_valid |=> frm_done)
      else $error("frame verdict missing");
   unl_pass_a: assert property (frm_valid && counted && unl[bkt] |=> !frm_drop)
      else $error("frame on an unlimited bucket was dropped");
   drop_flag_a: assert property (over && !fc_on |=> drop_seen)
      else $error("drop not recorded in status");

   drop_c: cover property (frm_valid && over && !fc_on ##1 frm_drop);
   fc_c: cover property (fc_on && over ##1 flow_ctrl);
   commit_c: cover property (reg_wr && reg_addr == OFS_LIM7);
   refill_c: cover property (fill_vld && fill_bkt == 3'h7);
   unl_c: cover property (frm_valid && counted && unl[bkt]);
endmodule
`default_nettype wire

// File: iprl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import iprl_pkg::*;
;
   // short refill period keeps a round to a few hundred cycles
   localparam int T = 400;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] link_speed = 2'h0;
   logic fc_enable = 1'b0;
   logic frm_valid = 1'b0;
   logic [13:0] frm_len = 14'h0000;
   logic [2:0] frm_prio = 3'h0;
   logic frm_bcast = 1'b0;
   logic frm_mcast = 1'b0;
   logic frm_flood = 1'b0;
   logic [7:0] reg_rdata;
   logic frm_done;
   logic frm_drop;
   logic flow_ctrl;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   int rel = 0;
   logic [15:0] lf = 16'h001f;
   logic [6:0] shd [8];
   logic [6:0] act [8];
   logic [6:0] nc [8];
   logic [6:0] codes [8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h32, 7'h65, 7'h68, 7'h78};
   longint cr [8];
   logic [7:0] cfg_m = 8'h00;
   logic [1:0] spd_m = 2'h0;
   logic fce_m = 1'b0;
   logic fc_exp = 1'b0;
   logic dseen = 1'b0;

   always #2 core_clk = ~core_clk;

   iprl_limiter #(.TICK_CYCLES(T), .LEN_W(14)) dut_u (
      .core_clk(core_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .link_speed(link_speed),
      .fc_enable(fc_enable),
      .frm_valid(frm_valid),
      .frm_len(frm_len),
      .frm_prio(frm_prio),
      .frm_bcast(frm_bcast),
      .frm_mcast(frm_mcast),
      .frm_flood(frm_flood),
      .frm_done(frm_done),
      .frm_drop(frm_drop),
      .flow_ctrl(flow_ctrl)
   );

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc > 50000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic int rn();
      lf = lfsr_next(lf);
      return int'(lf);
   endfunction

   // credit per refill window: bits, or hundredths of a packet
   function automatic longint exp_credit(input int c, input int s, input logic p);
      int m;
      m = c - 100;
      if (c > 115)
         return -1;
      if (s == 3)
         s = 2;
      if (!p) begin
         if (c == 0)
            return (s == 0) ? 100000 : (s == 1) ? 1000000 : 10000000;
         if (c <= 10 || (c <= 100 && s == 1))
            return c * 10000;
         if (c <= 100)
            return (s == 0) ? 100000 : c * 100000;
         return (s == 0 || (s == 1 && m > 3)) ? m * 640 : m * 6400;
      end
      if (c == 0)
         return (s == 0) ? 19200 : (s == 1) ? 192000 : 1920000;
      if (c <= 100)
         return (s == 2) ? c * 19200 : (s == 0 && c > 10) ? 19200 : c * 1920;
      return ((m == 1) ? 64 : (m - 1) * 128) * ((s == 2) ? 10 : 1);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, e);
   endtask

   // park the frame traffic well clear of the refill walk
   task automatic sync_refill();
      while ((cyc - rel) % T != T - 20)
         @(posedge core_clk);
      while ((cyc - rel) % T != 40)
         @(posedge core_clk);
      for (int i = 0; i < 8; i++)
         cr[i] = exp_credit(act[i], spd_m, cfg_m[CFG_PPS_BIT]);
      fc_exp = 1'b0;
   endtask

   task automatic cfg_round(input logic [7:0] c, input logic [1:0] s, input logic fe,
                            input logic commit);
      rd(OFS_STAT, {6'h00, dseen, fc_exp});
      dseen = 1'b0;
      wr(OFS_CFG, c);
      cfg_m = c & 8'h7f;
      link_speed <= s;
      fc_enable <= fe;
      spd_m = s;
      fce_m = fe;
      for (int i = 0; i < 7; i++) begin
         wr(OFS_LIM0 + 8'(i), {1'b1, nc[i]});
         shd[i] = nc[i];
      end
      if (commit) begin
         wr(OFS_LIM7, {1'b1, nc[7]});
         shd[7] = nc[7];
         for (int i = 0; i < 8; i++)
            act[i] = shd[i];
      end
      rd(OFS_CFG, cfg_m);
      for (int i = 0; i < 8; i++)
         rd(OFS_LIM0 + 8'(i), {1'b0, shd[i]});
      sync_refill();
   endtask

   task automatic send(input int len, input int pr, input logic [2:0] cls);
      logic cnt;
      int b;
      longint cost;
      logic ed;
      case (cfg_m[3:2])
         2'h0: cnt = 1'b1;
         2'h1: cnt = |cls;
         2'h2: cnt = cls[2] | cls[1];
         default: cnt = cls[2];
      endcase
      b = cfg_m[CFG_PORT_BIT] ? 0 : pr;
      cost = cfg_m[CFG_PPS_BIT] ? 100 :
             (len + (cfg_m[CFG_IFG_BIT] ? 12 : 0) +
              ((cfg_m[CFG_PRE_BIT] && !cfg_m[CFG_PPS_BIT]) ? 8 : 0)) * 8;
      ed = 1'b0;
      if (cnt && cr[b] >= 0) begin
         if (cr[b] >= cost) begin
            cr[b] -= cost;
         end else begin
            cr[b] = 0;
            if (cfg_m[CFG_FC_BIT] && fce_m)
               fc_exp = 1'b1;
            else
               ed = 1'b1;
         end
      end
      dseen |= ed;
      @(posedge core_clk);
      frm_valid <= 1'b1;
      frm_len <= 14'(len);
      frm_prio <= 3'(pr);
      {frm_bcast, frm_mcast, frm_flood} <= cls;
      @(posedge core_clk);
      frm_valid <= 1'b0;
      #1;
      check(frm_done, 1);
      check(frm_drop, ed);
      check(flow_ctrl, fc_exp);
   endtask

   initial begin
      int l;
      int p;
      for (int i = 0; i < 8; i++) begin
         shd[i] = 7'h00;
         act[i] = 7'h00;
      end
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rel = cyc;
      rd(OFS_CFG, 8'h00);
      for (int i = 0; i < 8; i++)
         rd(OFS_LIM0 + 8'(i), 8'h00);
      rd(8'h04, 8'h00);
      wr(8'h04, 8'hff);
      rd(OFS_CFG, 8'h00);
      // exact-fit credit with gap and preamble bytes, then a one-byte frame on the emptied bucket
      nc = '{default: 7'h01};
      cfg_round(8'h03, SPD_100, 1'b0, 1'b1);
      send(1230, 0, 3'h0);
      send(1, 0, 3'h0);
      // overrun with flow control: frame passes, request raised, then dropped with enable
      cfg_round(8'h10, SPD_100, 1'b1, 1'b1);
      send(1250, 0, 3'h0);
      send(1, 0, 3'h0);
      @(posedge core_clk);
      fc_enable <= 1'b0;
      fce_m = 1'b0;
      fc_exp = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check(flow_ctrl, 0);
      // packet mode at 10M: preamble bit must not matter
      cfg_round(8'h21, SPD_10, 1'b0, 1'b1);
      repeat (21) send(64, 3, 3'h0);
      // random rounds; even rounds leave priority 7 unwritten
      for (int r = 0; r < 30; r++) begin
         for (int i = 0; i < 8; i++)
            nc[i] = codes[rn() % 8];
         cfg_round(8'(rn()), 2'(rn() % 3), 1'(rn()), 1'(r % 2));
         repeat (24) begin
            l = rn() % 960;
            p = rn() % 8;
            send(64 + l, p, 3'(rn()));
         end
      end
      rd(OFS_STAT, {6'h00, dseen, fc_exp});
      wrap_up();
   end
endmodule
`default_nettype wire
